//--- hdl/devmgmt_pkg.sv
// Operation
// - Reinitialize command forgets stored sync negotiation state of addressed target.
// - Next selection of that target sends the sync negotiation message again.
// - Parameter block is 16-bit words with fixed word offsets for each field.
// - Completion interrupt raised only when options bit 0 is set.
// - Vector word: error vector low byte, normal vector high byte.
// - Level word bits 0-2 pick interrupt level; level 0 only with interrupts off.
// - Target bus ID from unit bits 0-2, LUN from bits 3-5.
// - Unit bit 6 selects SCSI port 0 or port 1.
// - At completion write return status; zero success, non-zero error code.
// - Bus-device-reset command sends the reset message to the addressed target.
package devmgmt_pkg;
   // Parameter block word offsets.
   localparam logic [4:0] W_CMD_CODE = 5'h00;
   localparam logic [4:0] W_OPTIONS  = 5'h01;
   localparam logic [4:0] W_STATUS   = 5'h02;
   localparam logic [4:0] W_VECTORS  = 5'h04;
   localparam logic [4:0] W_LEVEL    = 5'h05;
   localparam logic [4:0] W_UNIT     = 5'h0f;
   localparam logic [4:0] W_LAST     = 5'h15;
   // Command codes handled here.
   localparam logic [15:0] CMD_REINIT    = 16'h004c;
   localparam logic [15:0] CMD_BUS_DEV_RST = 16'h004d;
   // Field positions.
   localparam int OPT_IRQ_EN_BIT = 0;
   localparam int UNIT_PORT_BIT  = 6;
   localparam int UNIT_LUN_LO    = 3;
   // Return status codes; non-zero values are arbitrary error codes.
   localparam logic [15:0] ST_OK        = 16'h0000;
   localparam logic [15:0] ST_BAD_CMD   = 16'h0021;
   localparam logic [15:0] ST_BAD_LEVEL = 16'h0022;
   localparam logic [15:0] ST_RESERVED  = 16'h0023;
   localparam logic [15:0] ST_MSG_FAIL  = 16'h0024;
   // Reset values.
   localparam logic [15:0] SYNC_DONE_RESET = 16'h0000;

   typedef enum logic [3:0] {
      S_IDLE   = 4'b0000,
      S_FETCH  = 4'b0001,
      S_WAIT   = 4'b0010,
      S_DECODE = 4'b0011,
      S_MSG    = 4'b0100,
      S_STATUS = 4'b0101,
      S_IRQ    = 4'b0110,
      S_DONE   = 4'b0111
   } exec_state_t;
endpackage : devmgmt_pkg

//--- hdl/block_port_if.sv
`timescale 1ns/1ps
// Carries the decoded parameter block from the fetcher to the executor.
interface block_port_if;
   logic [15:0] cmdCode;
   logic [15:0] options;
   logic [15:0] vectors;
   logic [15:0] level;
   logic [15:0] unitAddr;
   logic        rsvdNonZero;
   modport fetch (output cmdCode, options, vectors, level, unitAddr, rsvdNonZero);
   modport exec  (input cmdCode, options, vectors, level, unitAddr, rsvdNonZero);
endinterface : block_port_if

//--- hdl/param_block_fetch.sv
`timescale 1ns/1ps
module param_block_fetch
   import devmgmt_pkg::*;
(
   // Clock and reset.
   input  wire logic        core_clk,
   input  wire logic        reset,
   // Word capture.
   input  wire logic        capValid,
   input  wire logic [4:0]  capAddr,
   input  wire logic [15:0] capData,
   input  wire logic        clearRsvd,
   // Decoded block.
   block_port_if.fetch      blk
);
   logic [15:0] cmd_reg, opt_reg, vec_reg, lvl_reg, unit_reg;
   logic        rsvd_reg;

   // Each fetched field word lands in its field register by offset.
   // word offset decode
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         cmd_reg  <= 16'h0000;
         opt_reg  <= 16'h0000;
         vec_reg  <= 16'h0000;
         lvl_reg  <= 16'h0000;
         unit_reg <= 16'h0000;
      end else if (capValid) begin
         case (capAddr)
            W_CMD_CODE: cmd_reg  <= capData;
            W_OPTIONS:  opt_reg  <= capData;
            W_VECTORS:  vec_reg  <= capData;
            W_LEVEL:    lvl_reg  <= capData;
            W_UNIT:     unit_reg <= capData;
            default: ;
         endcase
      end
   end

   // Reserved words are noted when non-zero; the status word is host-don't-care.
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         rsvd_reg <= 1'b0;
      end else if (clearRsvd) begin
         rsvd_reg <= 1'b0;
      end else if (capValid && capData != 16'h0000 && capAddr != W_CMD_CODE && capAddr != W_OPTIONS
                   && capAddr != W_STATUS && capAddr != W_VECTORS && capAddr != W_LEVEL
                   && capAddr != W_UNIT) begin
         rsvd_reg <= 1'b1;
      end
   end

   assign blk.cmdCode     = cmd_reg;
   assign blk.options     = opt_reg;
   assign blk.vectors     = vec_reg;
   assign blk.level       = lvl_reg;
   assign blk.unitAddr    = unit_reg;
   assign blk.rsvdNonZero = rsvd_reg;
endmodule : param_block_fetch

//--- hdl/scsi_device_mgmt_cmd_exec.sv
`timescale 1ns/1ps
module scsi_device_mgmt_cmd_exec
   import devmgmt_pkg::*;
#(
   parameter int NUM_IDS = 8
)(
   // Clock and reset.
   input  wire logic        core_clk,
   input  wire logic        reset,
   // Command start and block memory read port.
   input  wire logic        cmdStart,
   output logic             cmdBusy,
   output logic             memRdEn,
   output logic [4:0]       memAddr,
   input  wire logic        memRdValid,
   input  wire logic [15:0] memRdData,
   // Return status write.
   output logic             memWrEn,
   output logic [15:0]      memWrData,
   input  wire logic        memWrAck,
   // SCSI message request to the port engines.
   output logic             msgReq,
   output logic             msgPortSel,
   output logic [2:0]       msgTargetId,
   output logic [2:0]       msgLun,
   input  wire logic        msgDone,
   input  wire logic        msgFail,
   // Selection sync negotiation query.
   input  wire logic        selValid,
   input  wire logic        selPort,
   input  wire logic [2:0]  selId,
   output logic             selSendSyncMsg,
   input  wire logic        syncAgreed,
   input  wire logic        syncAgreedPort,
   input  wire logic [2:0]  syncAgreedId,
   // Completion interrupt request.
   output logic             irqReq,
   output logic [2:0]       irqPriorityLevel,
   output logic [7:0]       irqVector,
   input  wire logic        irqAck,
   output logic             cmdDone
);
   import devmgmt_pkg::*;

   exec_state_t state_reg;
   logic [4:0]  addr_reg;
   logic [15:0] status_reg;
   logic [15:0] checkStatus;
   logic [2*NUM_IDS-1:0] syncDone_reg;
   logic        wantIrq;
   logic        isReinit, isBdr;
   logic [2:0]  tgtId;
   logic        tgtPort;
   logic [3:0]  tgtIdx;

   block_port_if blk ();

   param_block_fetch u_fetch (
      .core_clk  (core_clk),
      .reset     (reset),
      .capValid  (memRdValid),
      .capAddr   (addr_reg),
      .capData   (memRdData),
      .clearRsvd (cmdStart && state_reg == S_IDLE),
      .blk       (blk)
   );

   // Decoded fields of the parameter block.
   // id and port fields
   assign tgtId   = blk.unitAddr[2:0];
   assign tgtPort = blk.unitAddr[UNIT_PORT_BIT];
   assign tgtIdx  = {tgtPort, tgtId};
   assign wantIrq  = blk.options[OPT_IRQ_EN_BIT];
   assign isReinit = (blk.cmdCode == CMD_REINIT);
   assign isBdr    = (blk.cmdCode == CMD_BUS_DEV_RST);

   // Verdict on the fetched block, ready within the decode cycle itself.
   // The stored status lags by a cycle, so the message and the sync clear must act on this verdict instead.
   // level zero needs irq off
   always_comb begin
      checkStatus = ST_OK;
      if (!isReinit && !isBdr) begin
         checkStatus = ST_BAD_CMD;
      end else if (wantIrq && blk.level[2:0] == 3'h0) begin
         checkStatus = ST_BAD_LEVEL;
      end else if (blk.rsvdNonZero || blk.options[15:1] != 15'h0000 || blk.level[15:3] != 13'h0000
                   || blk.unitAddr[15:7] != 9'h000) begin
         checkStatus = ST_RESERVED;
      end
   end

   // Main sequencer: fetch words, execute, write status, then interrupt.
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         state_reg <= S_IDLE;
         addr_reg  <= 5'h00;
      end else begin
         case (state_reg)
            S_IDLE: begin
               if (cmdStart) begin
                  state_reg <= S_FETCH;
                  addr_reg  <= W_CMD_CODE;
               end
            end
            S_FETCH: state_reg <= S_WAIT;
            S_WAIT: begin
               if (memRdValid) begin
                  if (addr_reg == W_LAST) begin
                     state_reg <= S_DECODE;
                  end else begin
                     addr_reg  <= addr_reg + 5'h01;
                     state_reg <= S_FETCH;
                  end
               end
            end
            S_DECODE: begin
               if (isBdr && checkStatus == ST_OK) state_reg <= S_MSG;
               else state_reg <= S_STATUS;
            end
            S_MSG: if (msgDone) state_reg <= S_STATUS;
            S_STATUS: if (memWrAck) state_reg <= (wantIrq ? S_IRQ : S_DONE);
            S_IRQ: if (irqAck) state_reg <= S_DONE;
            S_DONE: state_reg <= S_IDLE;
            default: state_reg <= S_IDLE;
         endcase
      end
   end

   // Validation of the block sets the return status code.
   // return status value
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         status_reg <= ST_OK;
      end else if (state_reg == S_IDLE && cmdStart) begin
         status_reg <= ST_OK;
      end else if (state_reg == S_DECODE) begin
         status_reg <= checkStatus;
      end else if (state_reg == S_MSG && msgDone && msgFail) begin
         status_reg <= ST_MSG_FAIL;
      end
   end

   // Per-target sync negotiation memory; new agreements set, reinitialize clears.
   // Set wins over clear when both hit the same target in one cycle.
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         syncDone_reg <= SYNC_DONE_RESET[2*NUM_IDS-1:0];
      end else begin
         if (state_reg == S_DECODE && isReinit && checkStatus == ST_OK) begin
            syncDone_reg[tgtIdx] <= 1'b0;
         end
         if (syncAgreed) syncDone_reg[{syncAgreedPort, syncAgreedId}] <= 1'b1;
      end
   end

   // Selection asks whether the sync message must go out for this target.
   // renegotiate on selection
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) selSendSyncMsg <= 1'b0;
      else selSendSyncMsg <= selValid && !syncDone_reg[{selPort, selId}];
   end

   // Bus device reset message request held until the port engine answers.
   // send reset message
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         msgReq      <= 1'b0;
         msgPortSel  <= 1'b0;
         msgTargetId <= 3'h0;
         msgLun      <= 3'h0;
      end else begin
         msgReq      <= (state_reg == S_DECODE && isBdr && checkStatus == ST_OK) || (state_reg == S_MSG && !msgDone);
         msgPortSel  <= tgtPort;
         msgTargetId <= tgtId;
         msgLun      <= blk.unitAddr[UNIT_LUN_LO +: 3];
      end
   end

   // Memory strobes and status write data.
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         memRdEn   <= 1'b0;
         memAddr   <= 5'h00;
         memWrEn   <= 1'b0;
         memWrData <= 16'h0000;
         cmdBusy   <= 1'b0;
         cmdDone   <= 1'b0;
      end else begin
         memRdEn   <= (state_reg == S_FETCH);
         memAddr   <= (state_reg == S_STATUS || state_reg == S_MSG) ? W_STATUS : addr_reg;
         memWrEn   <= (state_reg == S_STATUS && !memWrAck);
         memWrData <= status_reg;
         cmdBusy   <= (state_reg != S_IDLE) || cmdStart;
         cmdDone   <= (state_reg == S_DONE);
      end
   end

   // Completion interrupt with vector chosen from the outcome.
   // vector by outcome
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         irqReq           <= 1'b0;
         irqPriorityLevel <= 3'h0;
         irqVector        <= 8'h00;
      end else begin
         irqReq           <= (state_reg == S_IRQ && !irqAck);
         irqPriorityLevel <= blk.level[2:0];
         irqVector        <= (status_reg == ST_OK) ? blk.vectors[15:8] : blk.vectors[7:0];
      end
   end

   // Interrupt never requested when the enable option is clear.
   property p_no_irq_when_disabled;
      @(posedge core_clk) disable iff (reset) irqReq |-> wantIrq;
   endproperty
   a_no_irq_when_disabled: assert property (p_no_irq_when_disabled) else $error("irq without enable");

   // Status must have been written before any interrupt.
   sequence s_status_write;
      memWrEn ##1 !memWrEn;
   endsequence
   property p_status_first;
      @(posedge core_clk) disable iff (reset) $rose(irqReq) |-> $past(memWrEn, 2) && !$past(memWrEn);
   endproperty
   a_status_first: assert property (p_status_first) else $error("irq before status");

   // Once the status write has ended, an enabled interrupt follows on the next cycle.
   property p_irq_after_status;
      @(posedge core_clk) disable iff (reset) s_status_write ##0 wantIrq |=> irqReq;
   endproperty
   a_irq_after_status: assert property (p_irq_after_status) else $error("irq missing after status");

   property p_vector_select;
      @(posedge core_clk) disable iff (reset)
         (state_reg == S_IRQ) |=> irqVector == ((status_reg == ST_OK) ? blk.vectors[15:8] : blk.vectors[7:0]);
   endproperty
   a_vector_select: assert property (p_vector_select) else $error("wrong vector");

   property p_sync_retry;
      @(posedge core_clk) disable iff (reset)
         selValid && !syncDone_reg[{selPort, selId}] |=> selSendSyncMsg;
   endproperty
   a_sync_retry: assert property (p_sync_retry) else $error("sync message not requested");

   property p_msg_target;
      @(posedge core_clk) disable iff (reset)
         msgReq |-> msgTargetId == tgtId && msgPortSel == tgtPort && msgLun == blk.unitAddr[5:3];
   endproperty
   a_msg_target: assert property (p_msg_target) else $error("message addressed wrongly");

   property p_msg_only_bdr;
      @(posedge core_clk) disable iff (reset) msgReq |-> isBdr;
   endproperty
   a_msg_only_bdr: assert property (p_msg_only_bdr) else $error("message for wrong command");

   property p_level_zero_err;
      @(posedge core_clk) disable iff (reset)
         state_reg == S_DECODE && (isReinit || isBdr) && wantIrq && blk.level[2:0] == 3'h0
         |=> status_reg == ST_BAD_LEVEL;
   endproperty
   a_level_zero_err: assert property (p_level_zero_err) else $error("level zero accepted");

   property p_status_addr;
      @(posedge core_clk) disable iff (reset) memWrEn |-> memAddr == W_STATUS;
   endproperty
   a_status_addr: assert property (p_status_addr) else $error("status written elsewhere");

   // A bad block never reaches the SCSI bus as a reset message.
   property p_no_msg_on_error;
      @(posedge core_clk) disable iff (reset) state_reg == S_DECODE && checkStatus != ST_OK |=> !msgReq;
   endproperty
   a_no_msg_on_error: assert property (p_no_msg_on_error) else $error("message sent for bad block");

   // An accepted reinitialize leaves the target unnegotiated, unless an agreement lands in that same cycle.
   property p_reinit_clears;
      @(posedge core_clk) disable iff (reset)
         state_reg == S_DECODE && isReinit && checkStatus == ST_OK
         && !(syncAgreed && {syncAgreedPort, syncAgreedId} == tgtIdx) |=> !syncDone_reg[tgtIdx];
   endproperty
   a_reinit_clears: assert property (p_reinit_clears) else $error("sync state kept after reinitialize");

   // The sync message request only ever answers a selection query.
   property p_sync_only_on_query;
      @(posedge core_clk) disable iff (reset) selSendSyncMsg |-> $past(selValid);
   endproperty
   a_sync_only_on_query: assert property (p_sync_only_on_query) else $error("sync request without query");

   // The reset message request stands until the port engine answers.
   property p_msg_held;
      @(posedge core_clk) disable iff (reset) msgReq && !msgDone |=> msgReq;
   endproperty
   a_msg_held: assert property (p_msg_held) else $error("message request dropped early");

   // The interrupt request stands until the host acknowledges it.
   property p_irq_held;
      @(posedge core_clk) disable iff (reset) irqReq && !irqAck |=> irqReq;
   endproperty
   a_irq_held: assert property (p_irq_held) else $error("interrupt request dropped early");

   // The level shown with the request is the one the host asked for.
   property p_irq_level;
      @(posedge core_clk) disable iff (reset) irqReq |-> irqPriorityLevel == blk.level[2:0];
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("wrong interrupt level");
endmodule : scsi_device_mgmt_cmd_exec

//--- verification/host_block_mem.sv
`timescale 1ns/1ps
module host_block_mem
   import devmgmt_pkg::*;
(
   // Clock and reset.
   input  wire logic        core_clk,
   input  wire logic        reset,
   // Block contents chosen by the host.
   input  wire logic [15:0] cmdW,
   input  wire logic [15:0] optW,
   input  wire logic [15:0] vecW,
   input  wire logic [15:0] lvlW,
   input  wire logic [15:0] unitW,
   input  wire logic [15:0] rsvdW,
   input  wire logic        slowMode,
   // Memory port.
   input  wire logic        memRdEn,
   input  wire logic [4:0]  memAddr,
   output logic             memRdValid,
   output logic [15:0]      memRdData,
   input  wire logic        memWrEn,
   input  wire logic [15:0] memWrData,
   output logic             memWrAck,
   // Observed status write.
   output logic [15:0]      statusSeen,
   output logic [4:0]       statusAddr,
   output int               wrCount
);
   logic       pend;
   logic [1:0] cnt;
   logic [4:0] addrReg;

   function automatic logic [15:0] word_at(logic [4:0] a);
      case (a)
         W_CMD_CODE: return cmdW;
         W_OPTIONS:  return optW;
         W_VECTORS:  return vecW;
         W_LEVEL:    return lvlW;
         W_UNIT:     return unitW;
         default:    return rsvdW;
      endcase
   endfunction : word_at

   // Read answer; between answers the data lines flip so stale data never looks valid.
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         pend       <= 1'b0;
         cnt        <= 2'h0;
         addrReg    <= 5'h00;
         memRdValid <= 1'b0;
         memRdData  <= 16'h0000;
      end else begin
         memRdValid <= 1'b0;
         memRdData  <= ~memRdData;
         if (memRdEn) begin
            pend    <= 1'b1;
            addrReg <= memAddr;
            cnt     <= slowMode ? 2'h2 : 2'h0;
         end else if (pend && cnt != 2'h0) begin
            cnt <= cnt - 2'h1;
         end else if (pend) begin
            pend       <= 1'b0;
            memRdValid <= 1'b1;
            memRdData  <= word_at(addrReg);
         end
      end
   end

   // Status write acknowledge, one pulse per held write.
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         memWrAck   <= 1'b0;
         statusSeen <= 16'h0000;
         statusAddr <= 5'h00;
         wrCount    <= 0;
      end else begin
         memWrAck <= memWrEn && !memWrAck;
         if (memWrEn && !memWrAck) begin
            statusSeen <= memWrData;
            statusAddr <= memAddr;
            wrCount    <= wrCount + 1;
         end
      end
   end
endmodule : host_block_mem

//--- verification/test_scsi_device_mgmt_cmd_exec.sv
`timescale 1ns/1ps
module test_scsi_device_mgmt_cmd_exec;
   import devmgmt_pkg::*;
   typedef struct packed {
      logic [15:0] cmd, opt, vec, lvl, unit, rsvd;
      logic        fail;
      logic [15:0] st;
      logic        msg, irq;
   } row_t;
   // Rows: code, options, vectors, level, unit, reserved fill, msgFail, status, msg, irq.
   // the first row stands in for a target swapped without the adapter noticing.
   // no sense request follows a reset message here; that belongs to the host's own recovery.
   localparam row_t ROWS [9] = '{
      '{16'h004c, 16'h0001, 16'ha53c, 16'h0003, 16'h0055, 16'h0000, 1'b0, 16'h0000, 1'b0, 1'b1},
      '{16'h004d, 16'h0001, 16'hc3d2, 16'h0007, 16'h003a, 16'h0000, 1'b0, 16'h0000, 1'b1, 1'b1},
      '{16'h004d, 16'h0001, 16'hc3d2, 16'h0001, 16'h0041, 16'h0000, 1'b1, 16'h0024, 1'b1, 1'b1},
      '{16'h004d, 16'h0000, 16'h0000, 16'h0000, 16'h0047, 16'h0000, 1'b0, 16'h0000, 1'b1, 1'b0},
      '{16'h004c, 16'h0001, 16'h7e81, 16'h0000, 16'h0003, 16'h0000, 1'b0, 16'h0022, 1'b0, 1'b1},
      '{16'h004e, 16'h0001, 16'h1122, 16'h0002, 16'h0000, 16'h0000, 1'b0, 16'h0021, 1'b0, 1'b1},
      '{16'h004c, 16'h0000, 16'h0000, 16'h0004, 16'h0083, 16'h0000, 1'b0, 16'h0023, 1'b0, 1'b0},
      '{16'h004c, 16'h0000, 16'h0000, 16'h0004, 16'h0003, 16'h0040, 1'b0, 16'h0023, 1'b0, 1'b0},
      '{16'h004d, 16'h0001, 16'h5aa5, 16'h0000, 16'h0002, 16'h0000, 1'b0, 16'h0022, 1'b0, 1'b1}};
   logic core_clk = 1'b0, reset = 1'b1, cmdStart = 1'b0, msgDone = 1'b0, msgFail = 1'b0, irqAck = 1'b0;
   logic selValid = 1'b0, selPort = 1'b0, syncAgreed = 1'b0, syncAgreedPort = 1'b0, slowMode = 1'b0;
   logic [2:0] selId = 3'h0, syncAgreedId = 3'h0;
   logic [15:0] cmdW = 16'h0, optW = 16'h0, vecW = 16'h0, lvlW = 16'h0, unitW = 16'h0, rsvdW = 16'h0;
   logic cmdBusy, memRdEn, memRdValid, memWrEn, memWrAck, msgReq, msgPortSel, selSendSyncMsg, irqReq, cmdDone;
   logic [4:0] memAddr, statusAddr;
   logic [15:0] memRdData, memWrData, statusSeen;
   logic [2:0] msgTargetId, msgLun, irqPriorityLevel;
   logic [7:0] irqVector;
   int wrCount, fail_count = 0, check_count = 0;

   // Free-running core clock, 100 MHz.
   always #5 core_clk = ~core_clk;

   scsi_device_mgmt_cmd_exec i_dut (.core_clk(core_clk), .reset(reset), .cmdStart(cmdStart),
      .cmdBusy(cmdBusy), .memRdEn(memRdEn), .memAddr(memAddr), .memRdValid(memRdValid),
      .memRdData(memRdData), .memWrEn(memWrEn), .memWrData(memWrData), .memWrAck(memWrAck),
      .msgReq(msgReq), .msgPortSel(msgPortSel), .msgTargetId(msgTargetId), .msgLun(msgLun),
      .msgDone(msgDone), .msgFail(msgFail), .selValid(selValid), .selPort(selPort), .selId(selId),
      .selSendSyncMsg(selSendSyncMsg), .syncAgreed(syncAgreed), .syncAgreedPort(syncAgreedPort),
      .syncAgreedId(syncAgreedId), .irqReq(irqReq), .irqPriorityLevel(irqPriorityLevel),
      .irqVector(irqVector), .irqAck(irqAck), .cmdDone(cmdDone));

   host_block_mem i_mem (.core_clk(core_clk), .reset(reset), .cmdW(cmdW), .optW(optW), .vecW(vecW),
      .lvlW(lvlW), .unitW(unitW), .rsvdW(rsvdW), .slowMode(slowMode), .memRdEn(memRdEn),
      .memAddr(memAddr), .memRdValid(memRdValid), .memRdData(memRdData), .memWrEn(memWrEn),
      .memWrData(memWrData), .memWrAck(memWrAck), .statusSeen(statusSeen), .statusAddr(statusAddr),
      .wrCount(wrCount));

   task automatic end_sim();
      if (fail_count == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : end_sim

   task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
      check_count++;
      if (g !== e) begin
         fail_count++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask : chk

   // Selection query; the answer is looked at one cycle after the query.
   task automatic sel(logic p, logic [2:0] id, logic e);
      @(posedge core_clk);
      selValid <= 1'b1;
      selPort  <= p;
      selId    <= id;
      @(posedge core_clk);
      selValid <= 1'b0;
      @(negedge core_clk);
      chk("sync_msg", {15'h0, e}, {15'h0, selSendSyncMsg});
   endtask : sel

   task automatic agree(logic p, logic [2:0] id);
      @(posedge core_clk);
      syncAgreed     <= 1'b1;
      syncAgreedPort <= p;
      syncAgreedId   <= id;
      @(posedge core_clk);
      syncAgreed <= 1'b0;
   endtask : agree

   // One command: load the block, start, serve message and interrupt, then compare.
   // commands go one at a time through the single entry, each after the last has ended.
   task automatic run(row_t r, logic slow);
      int  n;
      int  wc;
      logic fin, mSeen, iSeen;
      fin   = 1'b0;
      mSeen = 1'b0;
      iSeen = 1'b0;
      wc    = wrCount;
      @(posedge core_clk);
      {cmdW, optW, vecW, lvlW, unitW, rsvdW} <= {r.cmd, r.opt, r.vec, r.lvl, r.unit, r.rsvd};
      slowMode <= slow;
      cmdStart <= 1'b1;
      @(posedge core_clk);
      cmdStart <= 1'b0;
      for (n = 0; n < 400 && !fin; n++) begin
         @(negedge core_clk);
         if (msgReq === 1'b1 && !mSeen) begin
            mSeen = 1'b1;
            chk("msg_port", {15'h0, r.unit[6]}, {15'h0, msgPortSel});
            chk("msg_lun_id", {10'h0, r.unit[5:0]}, {10'h0, msgLun, msgTargetId});
            @(posedge core_clk);
            msgDone <= 1'b1;
            msgFail <= r.fail;
            @(posedge core_clk);
            msgDone <= 1'b0;
            msgFail <= 1'b0;
         end else if (irqReq === 1'b1 && !iSeen) begin
            iSeen = 1'b1;
            chk("irq_level", {13'h0, r.lvl[2:0]}, {13'h0, irqPriorityLevel});
            chk("irq_vector", {8'h0, (r.st == ST_OK) ? r.vec[15:8] : r.vec[7:0]}, {8'h0, irqVector});
            chk("status_first", 16'(wc + 1), 16'(wrCount));
            @(posedge core_clk);
            irqAck <= 1'b1;
            @(posedge core_clk);
            irqAck <= 1'b0;
         end else begin
            fin = (cmdDone === 1'b1);
         end
      end
      if (!fin) begin
         chk("cmd_done", 16'h1, 16'h0);
         end_sim();
      end
      chk("status", r.st, statusSeen);
      chk("status_addr", {11'h0, W_STATUS}, {11'h0, statusAddr});
      chk("msg_sent", {15'h0, r.msg}, {15'h0, mSeen});
      chk("irq_sent", {15'h0, r.irq}, {15'h0, iSeen});
   endtask : run

   // Reset, sync memory set-up, the table, then the sync state after the table.
   initial begin
      repeat (3) @(posedge core_clk);
      chk("reset_outs", 16'h0, {10'h0, cmdBusy, irqReq, msgReq, memWrEn, memRdEn, cmdDone});
      reset <= 1'b0;
      sel(1'b1, 3'h5, 1'b1);
      agree(1'b1, 3'h5);
      agree(1'b0, 3'h3);
      sel(1'b1, 3'h5, 1'b0);
      for (int i = 0; i < 9; i++) run(ROWS[i], i[0]);
      sel(1'b1, 3'h5, 1'b1);
      sel(1'b0, 3'h3, 1'b0);
      end_sim();
   end
endmodule : test_scsi_device_mgmt_cmd_exec
